// *** rx_station.sv ***
// Remote station model that hands received characters to the block
`timescale 1ns/1ps
module rx_station (
  input wire logic clk_i,
  output logic valid_o,
  output logic [7:0] data_o,
  output logic ninth_o,
  output logic perr_o,
  output logic flow_o,
  output logic xoff_o
);
  initial begin
    valid_o = 1'b0;
    data_o = 8'h00;
    ninth_o = 1'b0;
    perr_o = 1'b0;
    flow_o = 1'b0;
    xoff_o = 1'b0;
  end
  // ====================
  // One character a call; gap lets it answer slowly
  task automatic send(input logic [7:0] d, input logic n, input logic f, input int gap);
    @(posedge clk_i);
    valid_o <= 1'b1;
    data_o <= d;
    ninth_o <= n;
    perr_o <= f;
    flow_o <= f;
    xoff_o <= f;
    @(posedge clk_i);
    valid_o <= 1'b0;
    // Not held after the strobe, so stale values must not look valid
    data_o <= ~d;
    ninth_o <= ~n;
    perr_o <= ~f;
    flow_o <= ~f;
    xoff_o <= ~f;
    repeat (gap) @(posedge clk_i);
  endtask
endmodule // rx_station

// *** uart_md_pkg.sv ***
// Constants for the multidrop receive, option bits and interrupt enables block
// What this block does
// - Multidrop bit set and special-character enable clear selects normal multidrop receive.
// - Receiver off: drop data bytes; address bytes flag parity error, interrupt, enter FIFO.
// - Enabled receiver takes data; each new address byte raises line status.
// - Multidrop bit and special-character enable both set select automatic address mode.
// - Automatic mode compares address bytes to second xoff character; discards others.
// - Matching address enables receiver, enters FIFO with ninth bit as parity error.
// - A later non-matching address disables the receiver until the next match.
// - Divisor and fraction registers reachable only while the divisor-latch bit is set.
// - Polarity bit zero drives direction high transmitting; one inverts it.
// - Flow-character parity check bit decides if parity-errored xon/xoff still act.
// - Infrared pulse is 3/16 bit time, or 1/4 with the fast bit.
// - Receive data interrupt and status follow FIFO level against trigger level.
// - Data ready sets when a character enters the FIFO, clears when empty.
// - Line status bits report overrun, head errors, transmit empties, FIFO error.
// - Clear-to-send rising edge raises its interrupt when enabled with enhanced bit.
// - Request-to-send rising edge raises its interrupt when enabled with enhanced bit.
// - Xoff interrupt enable gates xoff reception; writable only with enhanced bit.
// - Modem status interrupt raised while any of four delta bits is set.
// - All interrupt enables reset to zero.
// - FIFO enabled with the low four enables clear means polled mode.
// - Line status enable gates overrun, framing, parity and break interrupts.
package uart_md_pkg;
  // ==========================================
  // Register word indexes
  localparam logic [3:0] IDX_RHR_DLL = 4'h0;
  localparam logic [3:0] IDX_IER_DLM = 4'h1;
  localparam logic [3:0] IDX_ISR_DLD = 4'h2;
  localparam logic [3:0] IDX_LCR = 4'h3;
  localparam logic [3:0] IDX_LSR = 4'h4;
  localparam logic [3:0] IDX_MSR = 4'h5;
  localparam logic [3:0] IDX_EFR = 4'h6;
  localparam logic [3:0] IDX_SECOND_XOFF_CHARACTER = 4'h7;
  localparam logic [3:0] IDX_RXTRIG = 4'h8;
  localparam logic [3:0] IDX_RXCTL = 4'h9;
  // ==========================================
  // Field positions
  localparam int DLD_POL = 7;
  localparam int DLD_MDROP = 6;
  localparam int DLD_XPAR = 5;
  localparam int DLD_FASTIR = 4;
  localparam int EFR_ENH = 4;
  localparam int EFR_SPEC = 5;
  localparam int LCR_DLAB = 7;
  localparam int LCR_PAR_LO = 3;
  localparam int FCR_FIFO_EN = 0;
  localparam int RXCTL_OFF = 0;
  localparam int ENT_PE = 8;
  localparam int ENT_FE = 9;
  localparam int ENT_BRK = 10;
  localparam int ENT_W = 11;
  // ==========================================
  // Values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RXTRIG_RESET = 8'h01;
  localparam logic [2:0] LCR_FORCE_ZERO = 3'h7;
  localparam logic [7:0] IER_LOW_MASK = 8'h0F;
  localparam logic [7:0] IER_ENH_MASK = 8'hE0;
  localparam logic [5:0] ISR_LSI = 6'h06;
  localparam logic [5:0] ISR_RXRDY = 6'h04;
  localparam logic [5:0] ISR_MSR = 6'h00;
  localparam logic [5:0] ISR_XOFF = 6'h10;
  localparam logic [5:0] ISR_FLOW = 6'h20;
  localparam logic [5:0] ISR_NONE = 6'h01;
  localparam logic [2:0] IR_SIXTEENTHS_SLOW = 3'h3;
  localparam logic [2:0] IR_SIXTEENTHS_FAST = 3'h4;
endpackage

// *** uart_multidrop.sv ***
// Multidrop receive path, option bits, line status and interrupt enables of one channel
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module uart_multidrop #(
  parameter int DEPTH = 256
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_ninth_i,
  input wire logic rx_parity_err_i,
  input wire logic rx_frame_err_i,
  input wire logic rx_break_i,
  input wire logic rx_flow_char_i,
  input wire logic rx_is_xoff_i,
  input wire logic tx_active_i,
  input wire logic tx_fifo_empty_i,
  input wire logic tx_shift_empty_i,
  input wire logic cts_n_i,
  input wire logic rts_n_i,
  input wire logic dsr_n_i,
  input wire logic ri_n_i,
  input wire logic cd_n_i,
  output logic dir_o,
  output logic flow_valid_o,
  output logic xoff_irq_o,
  output logic line_irq_o,
  output logic rx_data_irq_o,
  output logic modem_irq_o,
  output logic cts_irq_o,
  output logic rts_irq_o,
  output logic polled_mode_o,
  output logic rx_enabled_o,
  output logic [2:0] ir_pulse_o,
  output logic [15:0] baud_div_o,
  output logic [3:0] baud_frac_o
);
  localparam int AW = $clog2(DEPTH);

  // ==========================================
  // Helpers
  function automatic logic has_err(input logic [uart_md_pkg::ENT_W-1:0] e);
    has_err = e[uart_md_pkg::ENT_PE] | e[uart_md_pkg::ENT_FE] | e[uart_md_pkg::ENT_BRK];
  endfunction

  // ==========================================
  // Registers
  logic ack_reg;
  logic [7:0] dll_reg;
  logic [7:0] dlm_reg;
  logic [7:0] dld_reg;
  logic [7:0] ier_reg;
  logic [7:0] lcr_reg;
  logic [7:0] fcr_reg;
  logic [7:0] efr_reg;
  logic [7:0] second_xoff_character_reg;
  logic [7:0] rxtrig_reg;
  logic rx_off_reg;
  logic overrun_reg;
  logic lsi_reg;
  logic xoff_reg;
  logic cts_flag_reg;
  logic rts_flag_reg;
  logic cts_prev_reg;
  logic rts_prev_reg;
  logic [3:0] modem_prev_reg;
  logic [3:0] delta_reg;
  logic [uart_md_pkg::ENT_W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] err_count_reg;
  logic [7:0] rdata;

  // ==========================================
  // Bus decode
  logic acc;
  logic wr;
  logic rd;
  logic dlab;
  logic [3:0] idx;
  assign acc = cyc_i & stb_i & ~ack_reg;
  assign wr = acc & we_i & sel_i[0];
  assign rd = acc & ~we_i;
  assign idx = adr_i[5:2];
  assign dlab = lcr_reg[uart_md_pkg::LCR_DLAB];

  logic wr_dll;
  logic wr_dlm;
  logic wr_dld;
  logic wr_ier;
  logic wr_fcr;
  logic rd_rhr;
  logic rd_isr;
  logic rd_lsr;
  logic rd_msr;
  assign wr_dll = wr & idx == uart_md_pkg::IDX_RHR_DLL & dlab;
  assign wr_dlm = wr & idx == uart_md_pkg::IDX_IER_DLM & dlab;
  assign wr_dld = wr & idx == uart_md_pkg::IDX_ISR_DLD & dlab;
  assign wr_ier = wr & idx == uart_md_pkg::IDX_IER_DLM & ~dlab;
  assign wr_fcr = wr & idx == uart_md_pkg::IDX_ISR_DLD & ~dlab;
  assign rd_rhr = rd & idx == uart_md_pkg::IDX_RHR_DLL & ~dlab;
  assign rd_isr = rd & idx == uart_md_pkg::IDX_ISR_DLD & ~dlab;
  assign rd_lsr = rd & idx == uart_md_pkg::IDX_LSR;
  assign rd_msr = rd & idx == uart_md_pkg::IDX_MSR;

  // ==========================================
  // Receive acceptance
  logic mdrop;
  logic auto_md;
  logic forced_zero;
  logic pe_in;
  logic push;
  logic auto_on;
  logic auto_off;
  logic [uart_md_pkg::ENT_W-1:0] entry;
  assign mdrop = dld_reg[uart_md_pkg::DLD_MDROP];
  assign auto_md = mdrop & efr_reg[uart_md_pkg::EFR_SPEC];
  assign forced_zero = lcr_reg[uart_md_pkg::LCR_PAR_LO +: 3] == uart_md_pkg::LCR_FORCE_ZERO;

  always_comb begin
    // Address bytes carry a ninth bit of one, so forced parity zero flags them
    pe_in = forced_zero ? rx_ninth_i : rx_parity_err_i;
    push = 1'b0;
    auto_on = 1'b0;
    auto_off = 1'b0;
    if (rx_valid_i) begin
      if (!mdrop) begin
        push = 1'b1;
      end else if (!auto_md) begin
        push = rx_ninth_i | ~rx_off_reg;
      end else if (rx_ninth_i) begin
        push = rx_data_i == second_xoff_character_reg;
        auto_on = push;
        auto_off = ~push;
      end else begin
        push = ~rx_off_reg;
      end
    end
    entry = {rx_break_i, rx_frame_err_i, auto_md ? rx_ninth_i : pe_in, rx_data_i};
  end

  // ==========================================
  // Receive FIFO
  logic full;
  logic empty;
  logic push_ok;
  logic pop;
  logic overrun_ev;
  logic [uart_md_pkg::ENT_W-1:0] head;
  assign full = count_reg == (AW+1)'(DEPTH);
  assign empty = count_reg == '0;
  assign push_ok = push & ~full;
  assign overrun_ev = push & full;
  assign pop = rd_rhr & ~empty;
  assign head = mem[rd_ptr_reg];

  always_ff @(posedge clk_i) begin
    if (push_ok) begin
      mem[wr_ptr_reg] <= entry;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push_ok & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push_ok) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // Counting errored entries keeps the FIFO-wide error bit exact without a scan
  logic err_in;
  logic err_out;
  assign err_in = push_ok & has_err(entry);
  assign err_out = pop & has_err(head);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_count_reg <= '0;
    end else if (err_in & ~err_out) begin
      err_count_reg <= err_count_reg + 1'b1;
    end else if (err_out & ~err_in) begin
      err_count_reg <= err_count_reg - 1'b1;
    end
  end

  // ==========================================
  // Receiver enable, software and automatic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_off_reg <= 1'b0;
    end else if (auto_on) begin
      rx_off_reg <= 1'b0;
    end else if (auto_off) begin
      rx_off_reg <= 1'b1;
    end else if (wr & idx == uart_md_pkg::IDX_RXCTL) begin
      rx_off_reg <= dat_i[uart_md_pkg::RXCTL_OFF];
    end
  end

  // ==========================================
  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dll_reg <= uart_md_pkg::REG_RESET;
      dlm_reg <= uart_md_pkg::REG_RESET;
      dld_reg <= uart_md_pkg::REG_RESET;
    end else begin
      if (wr_dll) begin
        dll_reg <= dat_i[7:0];
      end
      if (wr_dlm) begin
        dlm_reg <= dat_i[7:0];
      end
      if (wr_dld) begin
        dld_reg <= dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lcr_reg <= uart_md_pkg::REG_RESET;
      fcr_reg <= uart_md_pkg::REG_RESET;
      efr_reg <= uart_md_pkg::REG_RESET;
      second_xoff_character_reg <= uart_md_pkg::REG_RESET;
      rxtrig_reg <= uart_md_pkg::RXTRIG_RESET;
    end else begin
      if (wr & idx == uart_md_pkg::IDX_LCR) begin
        lcr_reg <= dat_i[7:0];
      end
      if (wr_fcr) begin
        fcr_reg <= dat_i[7:0];
      end
      if (wr & idx == uart_md_pkg::IDX_EFR) begin
        efr_reg <= dat_i[7:0];
      end
      if (wr & idx == uart_md_pkg::IDX_SECOND_XOFF_CHARACTER) begin
        second_xoff_character_reg <= dat_i[7:0];
      end
      if (wr & idx == uart_md_pkg::IDX_RXTRIG) begin
        rxtrig_reg <= dat_i[7:0];
      end
    end
  end

  // Upper enables keep their value unless the enhanced bit opens them
  logic [7:0] ier_mask;
  assign ier_mask = efr_reg[uart_md_pkg::EFR_ENH] ?
      (uart_md_pkg::IER_LOW_MASK | uart_md_pkg::IER_ENH_MASK) : uart_md_pkg::IER_LOW_MASK;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ier_reg <= uart_md_pkg::REG_RESET;
    end else if (wr_ier) begin
      ier_reg <= (dat_i[7:0] & ier_mask) | (ier_reg & ~ier_mask & uart_md_pkg::IER_ENH_MASK);
    end
  end

  // ==========================================
  // Sticky event flags, set wins over clear
  logic flow_valid;
  assign flow_valid = rx_valid_i & rx_flow_char_i & ~(dld_reg[uart_md_pkg::DLD_XPAR] & pe_in);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overrun_reg <= 1'b0;
      lsi_reg <= 1'b0;
    end else begin
      overrun_reg <= overrun_ev | (overrun_reg & ~rd_lsr);
      lsi_reg <= overrun_ev | err_in | (lsi_reg & ~rd_lsr);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xoff_reg <= 1'b0;
    end else begin
      xoff_reg <= (flow_valid & rx_is_xoff_i) | (xoff_reg & ~rd_isr);
    end
  end

  logic cts_rise;
  logic rts_rise;
  logic [3:0] modem_now;
  assign cts_rise = cts_n_i & ~cts_prev_reg;
  assign rts_rise = rts_n_i & ~rts_prev_reg;
  assign modem_now = {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cts_prev_reg <= 1'b1;
      rts_prev_reg <= 1'b1;
      modem_prev_reg <= 4'hF;
      cts_flag_reg <= 1'b0;
      rts_flag_reg <= 1'b0;
      delta_reg <= 4'h0;
    end else begin
      cts_prev_reg <= cts_n_i;
      rts_prev_reg <= rts_n_i;
      modem_prev_reg <= modem_now;
      cts_flag_reg <= cts_rise | (cts_flag_reg & ~rd_msr);
      rts_flag_reg <= rts_rise | (rts_flag_reg & ~rd_msr);
      delta_reg <= (modem_now ^ modem_prev_reg) | (delta_reg & {4{~rd_msr}});
    end
  end

  // ==========================================
  // Status views
  logic rx_trig_hit;
  logic enh;
  logic modem_int;
  logic flow_int;
  logic [7:0] line_status_register;
  logic [7:0] interrupt_source_register;
  assign rx_trig_hit = fcr_reg[uart_md_pkg::FCR_FIFO_EN] & (count_reg >= (AW+1)'(rxtrig_reg));
  assign enh = efr_reg[uart_md_pkg::EFR_ENH];
  assign modem_int = ier_reg[3] & |delta_reg;
  assign flow_int = enh & ((ier_reg[7] & cts_flag_reg) | (ier_reg[6] & rts_flag_reg));
  assign line_status_register = {err_count_reg != '0, tx_fifo_empty_i & tx_shift_empty_i, tx_fifo_empty_i,
      head[uart_md_pkg::ENT_BRK] & ~empty, head[uart_md_pkg::ENT_FE] & ~empty,
      head[uart_md_pkg::ENT_PE] & ~empty, overrun_reg, ~empty};

  always_comb begin
    interrupt_source_register[7:6] = {2{fcr_reg[uart_md_pkg::FCR_FIFO_EN]}};
    if (ier_reg[2] & lsi_reg) begin
      interrupt_source_register[5:0] = uart_md_pkg::ISR_LSI;
    end else if (ier_reg[0] & rx_trig_hit) begin
      interrupt_source_register[5:0] = uart_md_pkg::ISR_RXRDY;
    end else if (modem_int) begin
      interrupt_source_register[5:0] = uart_md_pkg::ISR_MSR;
    end else if (ier_reg[5] & xoff_reg) begin
      interrupt_source_register[5:0] = uart_md_pkg::ISR_XOFF;
    end else if (flow_int) begin
      interrupt_source_register[5:0] = uart_md_pkg::ISR_FLOW;
    end else begin
      interrupt_source_register[5:0] = uart_md_pkg::ISR_NONE;
    end
  end

  // ==========================================
  // Read data mux
  always_comb begin
    rdata = 8'h00;
    unique case (idx)
      uart_md_pkg::IDX_RHR_DLL: rdata = dlab ? dll_reg : head[7:0];
      uart_md_pkg::IDX_IER_DLM: rdata = dlab ? dlm_reg : ier_reg;
      uart_md_pkg::IDX_ISR_DLD: rdata = dlab ? dld_reg : interrupt_source_register;
      uart_md_pkg::IDX_LCR: rdata = lcr_reg;
      uart_md_pkg::IDX_LSR: rdata = line_status_register;
      uart_md_pkg::IDX_MSR: rdata = {~cd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i, delta_reg};
      uart_md_pkg::IDX_EFR: rdata = efr_reg;
      uart_md_pkg::IDX_SECOND_XOFF_CHARACTER: rdata = second_xoff_character_reg;
      uart_md_pkg::IDX_RXTRIG: rdata = rxtrig_reg;
      uart_md_pkg::IDX_RXCTL: rdata = {7'h00, rx_off_reg};
      default: rdata = 8'h00;
    endcase
  end

  // ==========================================
  // Wishbone answer, registered, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_reg <= acc;
      if (rd) begin
        dat_o <= {24'h000000, rdata};
      end
    end
  end
  assign ack_o = ack_reg;

  // ==========================================
  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_o <= 1'b0;
      flow_valid_o <= 1'b0;
      xoff_irq_o <= 1'b0;
      line_irq_o <= 1'b0;
      rx_data_irq_o <= 1'b0;
      modem_irq_o <= 1'b0;
      cts_irq_o <= 1'b0;
      rts_irq_o <= 1'b0;
      polled_mode_o <= 1'b0;
      rx_enabled_o <= 1'b1;
      ir_pulse_o <= uart_md_pkg::IR_SIXTEENTHS_SLOW;
      baud_div_o <= 16'h0000;
      baud_frac_o <= 4'h0;
    end else begin
      dir_o <= tx_active_i ^ dld_reg[uart_md_pkg::DLD_POL];
      flow_valid_o <= flow_valid;
      xoff_irq_o <= ier_reg[5] & xoff_reg;
      line_irq_o <= ier_reg[2] & lsi_reg;
      rx_data_irq_o <= ier_reg[0] & rx_trig_hit;
      modem_irq_o <= modem_int;
      cts_irq_o <= enh & ier_reg[7] & cts_flag_reg;
      rts_irq_o <= enh & ier_reg[6] & rts_flag_reg;
      polled_mode_o <= fcr_reg[uart_md_pkg::FCR_FIFO_EN] & (ier_reg[3:0] == 4'h0);
      rx_enabled_o <= ~rx_off_reg;
      ir_pulse_o <= dld_reg[uart_md_pkg::DLD_FASTIR] ?
          uart_md_pkg::IR_SIXTEENTHS_FAST : uart_md_pkg::IR_SIXTEENTHS_SLOW;
      baud_div_o <= {dlm_reg, dll_reg};
      baud_frac_o <= dld_reg[3:0];
    end
  end
endmodule // uart_multidrop

// *** uart_multidrop_props.sv ***
// Checker for bus answers, receive enable, option outputs and interrupt gating
`timescale 1ns/1ps
module uart_multidrop_props #(
  parameter int DEPTH = 256
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] adr_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic rx_valid_i,
  input wire logic rx_flow_char_i,
  input wire logic tx_active_i,
  input wire logic dir_o,
  input wire logic flow_valid_o,
  input wire logic line_irq_o,
  input wire logic rx_data_irq_o,
  input wire logic modem_irq_o,
  input wire logic polled_mode_o,
  input wire logic rx_enabled_o,
  input wire logic [2:0] ir_pulse_o,
  input wire logic [15:0] baud_div_o,
  input wire logic [3:0] baud_frac_o
);
  // ====================
  // Bus steps
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence answer_s;
    ack_o ##1 !ack_o;
  endsequence
  // ====================
  // Properties
  ack_answer_a: assert property (req_s |=> answer_s)
    else $error("bus answer late or too long");
  reset_state_a: assert property (disable iff (1'b0) rst_i |=> !ack_o && rx_enabled_o
    && ir_pulse_o == uart_md_pkg::IR_SIXTEENTHS_SLOW && !line_irq_o && !modem_irq_o)
    else $error("state after reset wrong");
  divisor_write_a: assert property ($changed(baud_div_o) || $changed(baud_frac_o)
    |-> $past(ack_o) && $past(we_i, 2) && $past(adr_i[5:2], 2) <= 4'h2)
    else $error("divisor changed without a write");
  ir_width_a: assert property (ir_pulse_o == uart_md_pkg::IR_SIXTEENTHS_SLOW
    || ir_pulse_o == uart_md_pkg::IR_SIXTEENTHS_FAST)
    else $error("infrared width illegal");
  rx_enable_cause_a: assert property ($changed(rx_enabled_o)
    |-> $past(ack_o) || $past(rx_valid_i, 2))
    else $error("receiver enable moved with no cause");
  flow_cause_a: assert property (flow_valid_o |-> $past(rx_valid_i && rx_flow_char_i))
    else $error("flow pulse with no flow character");
  polled_quiet_a: assert property (polled_mode_o && $past(polled_mode_o)
    |-> !line_irq_o && !rx_data_irq_o && !modem_irq_o)
    else $error("interrupt raised in polled mode");
  dir_cause_a: assert property ($changed(dir_o)
    |-> $past(ack_o) || $past(rst_i) || $past(tx_active_i) != $past(tx_active_i, 2))
    else $error("direction moved with no cause");
endmodule // uart_multidrop_props

bind uart_multidrop uart_multidrop_props #(.DEPTH(DEPTH)) u_uart_multidrop_props (.*);

// *** uart_multidrop_tb.sv ***
// Bench with a reference queue for the multidrop receive block
`timescale 1ns/1ps
module uart_multidrop_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [5:0] adr_i = 6'h00;
  logic [31:0] dat_i = 32'h00000000, dat_o;
  logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, ack_o;
  logic [3:0] sel_i = 4'h0;
  logic rx_valid_i, rx_ninth_i, rx_parity_err_i, rx_flow_char_i, rx_is_xoff_i;
  logic [7:0] rx_data_i, v, sa, lo, hi;
  logic tx_active_i = 1'b0, tx_fifo_empty_i = 1'b1, tx_shift_empty_i = 1'b1;
  logic cts_n_i = 1'b1, rts_n_i = 1'b1, dsr_n_i = 1'b1, ri_n_i = 1'b1, cd_n_i = 1'b1;
  logic dir_o, flow_valid_o, xoff_irq_o, line_irq_o, rx_data_irq_o, modem_irq_o;
  logic cts_irq_o, rts_irq_o, polled_mode_o, rx_enabled_o;
  logic [2:0] ir_pulse_o;
  logic [15:0] baud_div_o;
  logic [3:0] baud_frac_o;
  int error_cnt = 0;
  int checks = 0;
  int q[$];

  uart_multidrop #(.DEPTH(16)) u_uart_multidrop (.*, .rx_frame_err_i(1'b0), .rx_break_i(1'b0));
  rx_station u_rx_station (.clk_i(clk_i), .valid_o(rx_valid_i), .data_o(rx_data_i),
    .ninth_o(rx_ninth_i), .perr_o(rx_parity_err_i), .flow_o(rx_flow_char_i), .xoff_o(rx_is_xoff_i));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // ====================
  // Shared tasks
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic ckb(input logic got, input logic exp);
    ck({7'h00, got}, {7'h00, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic [3:0] idx, input logic wr, input logic [7:0] d);
    @(posedge clk_i);
    adr_i <= {idx, 2'h0};
    dat_i <= {24'h000000, d};
    we_i <= wr;
    sel_i <= 4'hF;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    v = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic fraction_and_line_options(input logic [7:0] d, input logic [7:0] line_control_register);
    bus(uart_md_pkg::IDX_LCR, 1'b1, line_control_register | 8'h80);
    bus(uart_md_pkg::IDX_ISR_DLD, 1'b1, d);
    bus(uart_md_pkg::IDX_LCR, 1'b1, line_control_register);
  endtask
  task automatic rx(input logic [7:0] d, input logic n, input logic keep);
    u_rx_station.send(d, n, 1'b0, $urandom_range(2));
    if (keep) q.push_back({n, d});
    tick(3);
  endtask
  task automatic drain();
    int e;
    while (q.size() > 0) begin
      e = q.pop_front();
      bus(uart_md_pkg::IDX_LSR, 1'b0, 8'h00);
      ckb(v[0], 1'b1);
      ckb(v[2], e[8]);
      bus(uart_md_pkg::IDX_RHR_DLL, 1'b0, 8'h00);
      ck(v, e[7:0]);
    end
    bus(uart_md_pkg::IDX_LSR, 1'b0, 8'h00);
    ckb(v[0], 1'b0);
  endtask
  task automatic results();
    $display("counts: %0d checks, %0d mismatches", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ====================
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    $display("mismatch at %0t: run timed out", $time);
    results();
  end
  // ====================
  // Tests
  initial begin
    void'($urandom(91137));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(uart_md_pkg::IDX_IER_DLM, 1'b0, 8'h00);
    ck(v, uart_md_pkg::REG_RESET);
    bus(4'hF, 1'b1, 8'hFF);
    bus(4'hF, 1'b0, 8'h00);
    ck(v, 8'h00);
    $display("test 1 done");
    lo = 8'($urandom());
    hi = 8'($urandom());
    bus(uart_md_pkg::IDX_LCR, 1'b1, 8'h80);
    bus(uart_md_pkg::IDX_RHR_DLL, 1'b1, lo);
    bus(uart_md_pkg::IDX_IER_DLM, 1'b1, hi);
    bus(uart_md_pkg::IDX_ISR_DLD, 1'b1, 8'h9A);
    tx_active_i <= 1'b1;
    tick(3);
    ck(baud_div_o[15:8], hi);
    ck(baud_div_o[7:0], lo);
    ck({4'h0, baud_frac_o}, 8'h0A);
    ck({5'h00, ir_pulse_o}, 8'h04);
    ckb(dir_o, 1'b0);
    fraction_and_line_options(8'h0A, 8'h00);
    bus(uart_md_pkg::IDX_IER_DLM, 1'b1, 8'hFF);
    bus(uart_md_pkg::IDX_IER_DLM, 1'b0, 8'h00);
    ck(v, 8'h0F);
    ck(baud_div_o[15:8], hi);
    ck({5'h00, ir_pulse_o}, 8'h03);
    ckb(dir_o, 1'b1);
    tx_active_i <= 1'b0;
    tick(3);
    ckb(dir_o, 1'b0);
    $display("test 2 done");
    bus(uart_md_pkg::IDX_EFR, 1'b1, 8'h10);
    bus(uart_md_pkg::IDX_IER_DLM, 1'b1, 8'hFF);
    bus(uart_md_pkg::IDX_IER_DLM, 1'b0, 8'h00);
    ck(v, 8'hEF);
    bus(uart_md_pkg::IDX_IER_DLM, 1'b1, 8'hC8);
    cts_n_i <= 1'b0;
    tick(2);
    cts_n_i <= 1'b1;
    tick(4);
    ckb(cts_irq_o, 1'b1);
    ckb(modem_irq_o, 1'b1);
    ckb(rts_irq_o, 1'b0);
    bus(uart_md_pkg::IDX_MSR, 1'b0, 8'h00);
    ck({v[7:4], 4'h0}, 8'h00);
    rts_n_i <= 1'b0;
    tick(2);
    rts_n_i <= 1'b1;
    tick(4);
    ckb(rts_irq_o, 1'b1);
    bus(uart_md_pkg::IDX_MSR, 1'b0, 8'h00);
    bus(uart_md_pkg::IDX_IER_DLM, 1'b1, 8'h00);
    ri_n_i <= 1'b0;
    tick(4);
    ckb(cts_irq_o, 1'b0);
    ckb(modem_irq_o, 1'b0);
    bus(uart_md_pkg::IDX_IER_DLM, 1'b1, 8'h08);
    tick(3);
    ckb(modem_irq_o, 1'b1);
    bus(uart_md_pkg::IDX_MSR, 1'b0, 8'h00);
    $display("test 3 done");
    fraction_and_line_options(8'h40, 8'h38);
    bus(uart_md_pkg::IDX_RXCTL, 1'b1, 8'h01);
    bus(uart_md_pkg::IDX_IER_DLM, 1'b1, 8'h04);
    sa = 8'($urandom());
    rx(sa ^ 8'h5A, 1'b0, 1'b0);
    ckb(line_irq_o, 1'b0);
    rx(sa, 1'b1, 1'b1);
    ckb(line_irq_o, 1'b1);
    drain();
    tick(2);
    ckb(line_irq_o, 1'b0);
    bus(uart_md_pkg::IDX_RXCTL, 1'b1, 8'h00);
    rx(8'($urandom()), 1'b0, 1'b1);
    rx(sa ^ 8'h01, 1'b1, 1'b1);
    ckb(line_irq_o, 1'b1);
    drain();
    bus(uart_md_pkg::IDX_RXCTL, 1'b1, 8'h01);
    $display("test 4 done");
    bus(uart_md_pkg::IDX_EFR, 1'b1, 8'h30);
    bus(uart_md_pkg::IDX_SECOND_XOFF_CHARACTER, 1'b1, sa);
    rx(sa, 1'b0, 1'b0);
    rx(sa ^ 8'h80, 1'b1, 1'b0);
    ckb(rx_enabled_o, 1'b0);
    ckb(line_irq_o, 1'b0);
    rx(sa, 1'b1, 1'b1);
    ckb(rx_enabled_o, 1'b1);
    ckb(line_irq_o, 1'b1);
    lo = 8'($urandom());
    rx(lo, 1'b0, 1'b1);
    rx(sa ^ 8'h01, 1'b1, 1'b0);
    ckb(rx_enabled_o, 1'b0);
    rx(lo, 1'b0, 1'b0);
    drain();
    $display("test 5 done");
    fraction_and_line_options(8'h00, 8'h03);
    bus(uart_md_pkg::IDX_EFR, 1'b1, 8'h10);
    bus(uart_md_pkg::IDX_ISR_DLD, 1'b1, 8'h01);
    bus(uart_md_pkg::IDX_RXTRIG, 1'b1, 8'h02);
    bus(uart_md_pkg::IDX_IER_DLM, 1'b1, 8'h01);
    rx(lo, 1'b0, 1'b1);
    ckb(rx_data_irq_o, 1'b0);
    rx(~lo, 1'b0, 1'b1);
    ckb(rx_data_irq_o, 1'b1);
    bus(uart_md_pkg::IDX_RHR_DLL, 1'b0, 8'h00);
    ck(v, 8'(q.pop_front()));
    tick(3);
    ckb(rx_data_irq_o, 1'b0);
    drain();
    bus(uart_md_pkg::IDX_IER_DLM, 1'b1, 8'h00);
    tx_shift_empty_i <= 1'b0;
    tick(3);
    ckb(polled_mode_o, 1'b1);
    bus(uart_md_pkg::IDX_LSR, 1'b0, 8'h00);
    ck({6'h00, v[6:5]}, 8'h01);
    $display("test 6 done");
    bus(uart_md_pkg::IDX_IER_DLM, 1'b1, 8'h20);
    for (int i = 0; i < 2; i++) begin
      fraction_and_line_options((i == 0) ? 8'h00 : 8'h20, 8'h03);
      u_rx_station.send(8'h13, 1'b0, 1'b1, 0);
      tick(1);
      ckb(flow_valid_o, i == 0);
      tick(2);
      ckb(xoff_irq_o, i == 0);
      bus(uart_md_pkg::IDX_ISR_DLD, 1'b0, 8'h00);
      ck(v, {2'b11, (i == 0) ? uart_md_pkg::ISR_XOFF : uart_md_pkg::ISR_NONE});
    end
    $display("test 7 done");
    results();
  end
endmodule // uart_multidrop_tb
